/* logic/branch_target_pkg.sv */
// Shared constants and types for the next-instruction address generator.
// Assumes a 16-bit program address space and byte-wide program and stack memory.
package branch_target_pkg;

	localparam int ADDR_W = 16;
	localparam int LEN_W = 3;
	localparam logic [15:0] PROGRAM_COUNTER_RESET = 16'h0000;
	localparam logic [15:0] STACK_POINTER_RESET = 16'h0000;
	localparam logic [15:0] TABLE_BASE = 16'h0040;
	localparam logic [15:0] TABLE_LAST = 16'h007F;
	localparam int SLOT_LSB = 1;
	localparam int SLOT_MSB = 5;
	localparam int DISP_SIGN_BIT = 7;
	localparam logic [15:0] STACK_STEP = 16'h0001;

	typedef enum logic [2:0] {
		OP_NEXT,
		OP_REL_JUMP,
		OP_COND_BRANCH,
		OP_JUMP,
		OP_CALL,
		OP_TABLE_CALL,
		OP_RETURN
	} op_kind_t;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_PUSH_LO,
		ST_TBL_A,
		ST_TBL_B,
		ST_TBL_C,
		ST_TBL_D,
		ST_RET_B,
		ST_RET_C,
		ST_RET_D
	} gen_state_t;

endpackage

/* logic/addr_calc_if.sv */
// Carries the operands and results of the address arithmetic between the sequencer
// and the adder block. Purely combinational signals in the core clock domain.
`timescale 1ns/1ns
interface addr_calc_if;
	logic [15:0] program_counter;
	logic [2:0] op_len;
	logic [7:0] branch_displacement;
	logic [4:0] table_slot_index;
	logic [15:0] next_addr;
	logic [15:0] rel_target;
	logic [15:0] slot_addr;

	modport calc (
		input program_counter,
		input op_len,
		input branch_displacement,
		input table_slot_index,
		output next_addr,
		output rel_target,
		output slot_addr
	);

	modport user (
		output program_counter,
		output op_len,
		output branch_displacement,
		output table_slot_index,
		input next_addr,
		input rel_target,
		input slot_addr
	);
endinterface

/* logic/target_adder.sv */
// Address arithmetic: sequential advance, relative target and table slot address.
// Assumes its operands are stable during the cycle in which the results are used.
`timescale 1ns/1ns
module target_adder
	import branch_target_pkg::*;
(
	addr_calc_if.calc calc
);
	logic [15:0] disp_ext;

	// The next address moves one step per instruction byte.
	assign calc.next_addr = calc.program_counter + {13'h0000, calc.op_len};

	// The displacement is widened by copying its sign bit into the upper byte.
	assign disp_ext = {{8{calc.branch_displacement[DISP_SIGN_BIT]}},
		calc.branch_displacement};

	// The target is taken relative to the instruction after the branch.
	assign calc.rel_target = calc.next_addr + disp_ext;

	// Each table slot holds two bytes, so the slot index is doubled.
	assign calc.slot_addr = TABLE_BASE + {10'h000, calc.table_slot_index, 1'b0};

endmodule

/* logic/branch_target_address_gen.sv */
// Next-instruction address generator with return-address push, table read and pop.
// Assumes memory answers a read on the cycle after mem_req with mem_we low.
//
// Functional notes
// - Without a branch the program counter advances by one per instruction byte.
// - A relative branch loads the program counter with the next address plus the displacement.
// - The displacement is signed with bit 7 as sign, reaching -128 to +127 bytes.
// - Widening the displacement fills the upper byte with copies of its sign bit.
// - The relative jump and every taken conditional branch use the relative target.
// - The absolute jump and call load the program counter with the 16-bit target.
// - A table call selects its slot from opcode bits 1 to 5 and jumps to its contents.
// - Table slots lie at program addresses 40H to 7FH and may point anywhere.
// - The stack pointer drops before each stack write and rises after each stack read.
`timescale 1ns/1ns
module branch_target_address_gen
	import branch_target_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic op_valid,
	input wire op_kind_t op_kind,
	input wire logic [2:0] op_len,
	input wire logic [7:0] instr_opcode,
	input wire logic [7:0] branch_displacement,
	input wire logic [15:0] absolute_target,
	input wire logic cond_taken,
	input wire logic sp_load,
	input wire logic [15:0] sp_load_value,
	input wire logic [7:0] mem_rdata,
	output logic op_ready,
	output logic [15:0] program_counter,
	output logic [15:0] stack_pointer,
	output logic mem_req,
	output logic mem_we,
	output logic [15:0] mem_addr,
	output logic [7:0] mem_wdata
);
	typedef struct packed {
		gen_state_t state;
		logic [15:0] program_counter;
		logic [15:0] stack_pointer;
		logic [15:0] ret_addr;
		logic [15:0] target;
		logic [15:0] tbl_addr;
		logic [7:0] low_byte;
		logic is_table;
		logic mem_req;
		logic mem_we;
		logic [15:0] mem_addr;
		logic [7:0] mem_wdata;
	} gen_regs_t;

	gen_regs_t regs_r;
	gen_regs_t regs_nxt;
	logic accept;

	addr_calc_if calc_bus();

	assign calc_bus.program_counter = regs_r.program_counter;
	assign calc_bus.op_len = op_len;
	assign calc_bus.branch_displacement = branch_displacement;
	assign calc_bus.table_slot_index = instr_opcode[SLOT_MSB:SLOT_LSB];

	target_adder u_adder (
		.calc(calc_bus)
	);

	assign op_ready = (regs_r.state == ST_IDLE);
	assign accept = op_valid && op_ready;

	always_comb begin
		regs_nxt = regs_r;
		regs_nxt.mem_req = 1'b0;
		regs_nxt.mem_we = 1'b0;
		case (regs_r.state)
			ST_IDLE: begin
				if (op_valid) begin
					case (op_kind)
						OP_NEXT: begin
							regs_nxt.program_counter = calc_bus.next_addr;
						end
						OP_REL_JUMP: begin
							regs_nxt.program_counter = calc_bus.rel_target;
						end
						OP_COND_BRANCH: begin
							// A branch not taken falls through to the next instruction.
							regs_nxt.program_counter = cond_taken ? calc_bus.rel_target
								: calc_bus.next_addr;
						end
						OP_JUMP: begin
							regs_nxt.program_counter = absolute_target;
						end
						OP_CALL, OP_TABLE_CALL: begin
							// The high byte of the return address goes first, below the old top.
							regs_nxt.ret_addr = calc_bus.next_addr;
							regs_nxt.target = absolute_target;
							regs_nxt.tbl_addr = calc_bus.slot_addr;
							regs_nxt.is_table = (op_kind == OP_TABLE_CALL);
							regs_nxt.stack_pointer = regs_r.stack_pointer - STACK_STEP;
							regs_nxt.mem_req = 1'b1;
							regs_nxt.mem_we = 1'b1;
							regs_nxt.mem_addr = regs_r.stack_pointer - STACK_STEP;
							regs_nxt.mem_wdata = calc_bus.next_addr[15:8];
							regs_nxt.state = ST_PUSH_LO;
						end
						OP_RETURN: begin
							regs_nxt.stack_pointer = regs_r.stack_pointer + STACK_STEP;
							regs_nxt.mem_req = 1'b1;
							regs_nxt.mem_addr = regs_r.stack_pointer;
							regs_nxt.state = ST_RET_B;
						end
						default: begin
							regs_nxt.state = ST_IDLE;
						end
					endcase
				end else if (sp_load) begin
					regs_nxt.stack_pointer = sp_load_value;
				end
			end
			ST_PUSH_LO: begin
				regs_nxt.stack_pointer = regs_r.stack_pointer - STACK_STEP;
				regs_nxt.mem_req = 1'b1;
				regs_nxt.mem_we = 1'b1;
				regs_nxt.mem_addr = regs_r.stack_pointer - STACK_STEP;
				regs_nxt.mem_wdata = regs_r.ret_addr[7:0];
				if (regs_r.is_table) begin
					regs_nxt.state = ST_TBL_A;
				end else begin
					regs_nxt.program_counter = regs_r.target;
					regs_nxt.state = ST_IDLE;
				end
			end
			ST_TBL_A: begin
				regs_nxt.mem_req = 1'b1;
				regs_nxt.mem_addr = regs_r.tbl_addr;
				regs_nxt.state = ST_TBL_B;
			end
			ST_TBL_B: begin
				regs_nxt.mem_req = 1'b1;
				regs_nxt.mem_addr = regs_r.tbl_addr + 16'h0001;
				regs_nxt.state = ST_TBL_C;
			end
			ST_TBL_C: begin
				regs_nxt.low_byte = mem_rdata;
				regs_nxt.state = ST_TBL_D;
			end
			ST_TBL_D: begin
				regs_nxt.program_counter = {mem_rdata, regs_r.low_byte};
				regs_nxt.state = ST_IDLE;
			end
			ST_RET_B: begin
				regs_nxt.stack_pointer = regs_r.stack_pointer + STACK_STEP;
				regs_nxt.mem_req = 1'b1;
				regs_nxt.mem_addr = regs_r.stack_pointer;
				regs_nxt.state = ST_RET_C;
			end
			ST_RET_C: begin
				regs_nxt.low_byte = mem_rdata;
				regs_nxt.state = ST_RET_D;
			end
			ST_RET_D: begin
				regs_nxt.program_counter = {mem_rdata, regs_r.low_byte};
				regs_nxt.state = ST_IDLE;
			end
			default: begin
				regs_nxt.state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			regs_r <= '{state: ST_IDLE, program_counter: PROGRAM_COUNTER_RESET,
				stack_pointer: STACK_POINTER_RESET, default: '0};
		end else begin
			regs_r <= regs_nxt;
		end
	end

	assign program_counter = regs_r.program_counter;
	assign stack_pointer = regs_r.stack_pointer;
	assign mem_req = regs_r.mem_req;
	assign mem_we = regs_r.mem_we;
	assign mem_addr = regs_r.mem_addr;
	assign mem_wdata = regs_r.mem_wdata;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	AST_SEQ_ADVANCE: assert property (
		accept && op_kind == OP_NEXT |=>
		program_counter == $past(program_counter) + {13'h0000, $past(op_len)})
		else $error("Sequential advance did not add the instruction length.");

	AST_REL_TARGET: assert property (
		accept && op_kind == OP_REL_JUMP |=>
		program_counter == $past(program_counter) + {13'h0000, $past(op_len)}
		+ {{8{$past(branch_displacement[7])}}, $past(branch_displacement)})
		else $error("Relative jump target is wrong.");

	AST_REL_REACH: assert property (
		accept && op_kind == OP_REL_JUMP |=>
		($signed(16'(program_counter - $past(program_counter) - {13'h0000, $past(op_len)}))
		>= -16'sd128) && ($signed(16'(program_counter - $past(program_counter)
		- {13'h0000, $past(op_len)})) <= 16'sd127))
		else $error("Relative jump left the signed byte reach.");

	AST_SIGN_FILL: assert property (
		accept && op_kind == OP_REL_JUMP && branch_displacement[7] |=>
		program_counter < $past(program_counter) + {13'h0000, $past(op_len)}
		|| $past(program_counter) + {13'h0000, $past(op_len)} < 16'h0080)
		else $error("Negative displacement was not sign filled.");

	AST_COND_BRANCH: assert property (
		accept && op_kind == OP_COND_BRANCH && !cond_taken |=>
		program_counter == $past(program_counter) + {13'h0000, $past(op_len)})
		else $error("Untaken conditional branch did not fall through.");

	AST_JUMP_ABS: assert property (
		accept && op_kind == OP_JUMP |=> program_counter == $past(absolute_target))
		else $error("Absolute jump did not load the target.");

	AST_CALL_ORDER: assert property (
		accept && op_kind == OP_CALL |=>
		(mem_we && mem_addr == $past(stack_pointer) - 16'h0001
		&& program_counter == $past(program_counter))
		##1 (mem_we && program_counter == $past(absolute_target, 2)))
		else $error("Call did not push before loading the target.");

	AST_TABLE_READ: assert property (
		accept && op_kind == OP_TABLE_CALL |-> ##3
		(mem_req && !mem_we && mem_addr == TABLE_BASE
		+ {10'h000, $past(instr_opcode[5:1], 3), 1'b0})
		##1 (mem_req && !mem_we && mem_addr == $past(mem_addr) + 16'h0001))
		else $error("Table slot read address is wrong.");

	AST_TABLE_RANGE: assert property (
		(regs_r.state == ST_TBL_B || regs_r.state == ST_TBL_C) |->
		mem_addr >= TABLE_BASE && mem_addr <= TABLE_LAST)
		else $error("Table read left the vector area.");

	AST_POP_ORDER: assert property (
		accept && op_kind == OP_RETURN |=>
		mem_req && !mem_we && mem_addr == $past(stack_pointer)
		&& stack_pointer == $past(stack_pointer) + 16'h0001)
		else $error("Return did not read before raising the stack pointer.");

endmodule

/* test/prog_mem_model.sv */
// Behavioural program and stack memory on the far side of the address generator.
// Assumes one shared byte port with writes on request and reads answered a cycle later.
`timescale 1ns/1ns
module prog_mem_model (
	input wire logic mclk,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [15:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	output logic [7:0] mem_rdata
);
	logic [7:0] mem [0:65535];

	initial begin
		mem_rdata = 8'h00;
	end

	// Table entries live here too; every cycle without a read, writes included, inverts the byte shown.
	always @(posedge mclk) begin
		if (mem_req && mem_we) begin
			mem[mem_addr] <= mem_wdata;
		end
		if (mem_req && !mem_we) begin
			mem_rdata <= mem[mem_addr];
		end else begin
			mem_rdata <= ~mem_rdata;
		end
	end
endmodule

/* test/tb.sv */
// Self-checking bench for the next-instruction address generator.
// Assumes the memory model answers reads one cycle after the request.
`timescale 1ns/1ns
module tb;
	import branch_target_pkg::*;
	logic mclk, rst, op_valid, cond_taken, sp_load, op_ready, mem_req, mem_we;
	op_kind_t op_kind;
	logic [2:0] op_len;
	logic [7:0] instr_opcode, branch_displacement, mem_rdata, mem_wdata;
	logic [15:0] absolute_target, sp_load_value, program_counter, stack_pointer, mem_addr;
	int error_cnt = 0;
	int cmp_count = 0;
	int cyc = 0;
	int busy_cyc = 0;

	branch_target_address_gen branch_target_address_gen_inst (.mclk(mclk), .rst(rst),
		.op_valid(op_valid), .op_kind(op_kind), .op_len(op_len), .instr_opcode(instr_opcode),
		.branch_displacement(branch_displacement), .absolute_target(absolute_target),
		.cond_taken(cond_taken), .sp_load(sp_load), .sp_load_value(sp_load_value),
		.mem_rdata(mem_rdata), .op_ready(op_ready), .program_counter(program_counter),
		.stack_pointer(stack_pointer), .mem_req(mem_req), .mem_we(mem_we),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata));
	prog_mem_model prog_mem_model_inst (.mclk(mclk), .mem_req(mem_req), .mem_we(mem_we),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	task give_verdict;
		if (error_cnt == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			error_cnt++;
			give_verdict;
		end
	end

	task chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Offers one operation, releases it after the taking edge and waits for idle.
	task automatic run_op(op_kind_t k, logic [2:0] ln, logic [7:0] opc, logic [7:0] d,
		logic [15:0] t, logic c);
		int n = 0;
		@(posedge mclk);
		op_kind <= k;
		op_len <= ln;
		instr_opcode <= opc;
		branch_displacement <= d;
		absolute_target <= t;
		cond_taken <= c;
		op_valid <= 1'b1;
		@(posedge mclk);
		op_valid <= 1'b0;
		#1;
		while (op_ready !== 1'b1 && n < 20) begin
			@(posedge mclk);
			#1;
			n++;
		end
		busy_cyc = n;
	endtask

	// Relative target is next address plus the sign-extended displacement.
	task automatic rel_case(op_kind_t k, logic [2:0] ln, logic [7:0] d, logic c);
		logic [15:0] exp;
		exp = program_counter + {13'h0000, ln};
		if (c) exp = exp + {{8{d[7]}}, d};
		run_op(k, ln, 8'h00, d, 16'h0000, c);
		chk(program_counter, exp);
	endtask

	task scn_sequential;
		run_op(OP_NEXT, 3'h3, 8'h00, 8'h00, 16'h0000, 1'b0);
		chk(program_counter, 16'h0003);
	endtask

	task scn_relative;
		rel_case(OP_REL_JUMP, 3'h2, 8'h80, 1'b1);
		rel_case(OP_REL_JUMP, 3'h2, 8'h7F, 1'b1);
		rel_case(OP_COND_BRANCH, 3'h2, 8'h40, 1'b0);
		rel_case(OP_COND_BRANCH, 3'h2, 8'hF0, 1'b1);
	endtask

	task scn_absolute;
		run_op(OP_JUMP, 3'h3, 8'h00, 8'h00, 16'h1234, 1'b0);
		chk(program_counter, 16'h1234);
		chk(16'(busy_cyc), 16'h0000);
		run_op(OP_CALL, 3'h3, 8'h00, 8'h00, 16'h4000, 1'b0);
		chk(program_counter, 16'h4000);
		chk(16'(busy_cyc), 16'h0001);
		chk(stack_pointer, 16'hFEFE);
		// The low byte of the return address lands one edge after the jump.
		@(posedge mclk);
		#1;
		chk({8'h00, prog_mem_model_inst.mem[16'hFEFF]}, 16'h0012);
		chk({8'h00, prog_mem_model_inst.mem[16'hFEFE]}, 16'h0037);
	endtask

	task scn_table;
		run_op(OP_TABLE_CALL, 3'h1, 8'hBE, 8'h00, 16'h0000, 1'b0);
		chk(program_counter, 16'hABCD);
		chk(16'(busy_cyc), 16'h0005);
		chk(stack_pointer, 16'hFEFC);
		chk({prog_mem_model_inst.mem[16'hFEFD], prog_mem_model_inst.mem[16'hFEFC]},
			16'h4001);
		run_op(OP_TABLE_CALL, 3'h1, 8'h01, 8'h00, 16'h0000, 1'b0);
		chk(program_counter, 16'h5678);
		run_op(OP_RETURN, 3'h1, 8'h00, 8'h00, 16'h0000, 1'b0);
		chk(program_counter, 16'hABCE);
		chk(16'(busy_cyc), 16'h0003);
		chk(stack_pointer, 16'hFEFC);
	endtask

	task scn_return;
		run_op(OP_RETURN, 3'h1, 8'h00, 8'h00, 16'h0000, 1'b0);
		chk(program_counter, 16'h4001);
		run_op(OP_RETURN, 3'h1, 8'h00, 8'h00, 16'h0000, 1'b0);
		chk(program_counter, 16'h1237);
		chk(stack_pointer, 16'hFF00);
	endtask

	initial begin
		rst = 1'b1;
		op_valid = 1'b0;
		op_kind = OP_NEXT;
		op_len = 3'h0;
		instr_opcode = 8'h00;
		branch_displacement = 8'h00;
		absolute_target = 16'h0000;
		cond_taken = 1'b0;
		sp_load = 1'b0;
		sp_load_value = 16'hFF00;
		prog_mem_model_inst.mem[16'h007E] = 8'hCD;
		prog_mem_model_inst.mem[16'h007F] = 8'hAB;
		prog_mem_model_inst.mem[16'h0040] = 8'h78;
		prog_mem_model_inst.mem[16'h0041] = 8'h56;
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		sp_load <= 1'b1;
		#1;
		chk(program_counter, PROGRAM_COUNTER_RESET);
		chk(stack_pointer, STACK_POINTER_RESET);
		@(posedge mclk);
		sp_load <= 1'b0;
		#1;
		chk(stack_pointer, 16'hFF00);
		scn_sequential();
		scn_relative();
		scn_absolute();
		scn_table();
		scn_return();
		give_verdict;
	end
endmodule
